// file: src/acq_pkg.sv
package acq_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_NS      = 5;        // pclk period
	localparam int unsigned TB_NS       = 50;       // 20 MHz time base period
	localparam int unsigned TB_HZ       = 20000000; // Time base rate
	localparam int unsigned MAX_RATE_HZ = 250000;   // Pacer ceiling
	localparam int unsigned TB_CYC      = TB_NS / CLK_NS;
	localparam logic [3:0]  TB_LAST     = 4'(TB_CYC - 1);
	localparam logic [31:0] MIN_DIV     = 32'(TB_HZ / MAX_RATE_HZ);
	localparam int unsigned MIN_GAP_CYC = (TB_HZ / MAX_RATE_HZ) * TB_CYC;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int unsigned NCH    = 16; // Input channels
	localparam int unsigned CH_W   = 4;  // Channel number width
	localparam int unsigned ADC_W  = 12; // Result width
	localparam int unsigned MODE_W = 3;  // Trigger mode field

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_CHAN     = 8'h04;
	localparam logic [7:0] OFS_ITER     = 8'h08;
	localparam logic [7:0] OFS_SCAN_DIV = 8'h0c;
	localparam logic [7:0] OFS_PACE_DIV = 8'h10;
	localparam logic [7:0] OFS_TRIG_CNT = 8'h14;
	localparam logic [7:0] OFS_SCAN_CNT = 8'h18;
	localparam logic [7:0] OFS_STATUS   = 8'h1c;
	localparam logic [7:0] OFS_RESULT   = 8'h40;
	localparam logic [7:0] OFS_RES_END  = 8'h80;

	// ****************************************
	// Control word fields
	// ****************************************
	localparam int unsigned B_RUN       = 0;  // Start / stop
	localparam int unsigned B_PACER     = 1;  // 1 pacer, 0 polling
	localparam int unsigned B_MODE      = 2;  // Trigger mode, 3 bits
	localparam int unsigned B_TRIG_FALL = 5;  // Falling trigger edge
	localparam int unsigned B_PAUSE_EN  = 6;  // Pause gate enable
	localparam int unsigned B_PAUSE_LOW = 7;  // Pass on low level
	localparam int unsigned B_SCAN_EXT  = 8;  // External scan pacer
	localparam int unsigned B_PACE_EXT  = 9;  // External sample pacer
	localparam int unsigned B_SINGLE    = 10; // Sample pacer drives scan
	localparam int unsigned CTRL_W      = 11;
	localparam int unsigned CH_LAST_LSB = 4;  // Channel word: last above first
	localparam int unsigned ST_LSB      = 5;  // Status: state field

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [MODE_W-1:0] {
		MODE_FREE, MODE_POST, MODE_DELAY, MODE_ABOUT, MODE_PRE
	} trig_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_WAIT, ST_DELAY, ST_ACQ, ST_HOLD, ST_DONE
	} acq_state_t;

	// Conversion request to the converter
	typedef struct packed {
		logic            strobe;
		logic [CH_W-1:0] chan;
	} conv_req_t;

	// Converted sample toward the buffer
	typedef struct packed {
		logic             valid;
		logic [CH_W-1:0]  chan;
		logic [ADC_W-1:0] data;
	} sample_t;

	// Synchroniser stages
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_t;

endpackage

// file: src/edge_sync.sv
`timescale 1ns/10ps
module edge_sync
	import acq_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Raw pin
	input  wire logic pin,
	// Synchronised level and edges
	output logic      level,
	output logic      rise,
	output logic      fall
);

	sync_t q; // Stage registers
	sync_t d; // Next stages

	// Shift chain; s1 feeds only s2
	always_comb begin
		d = '{s1: pin, s2: q.s1, s3: q.s2};
	end

	// Register the chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Edges come from stages two and three only
	assign level = q.s2;
	assign rise  = q.s2 & ~q.s3;
	assign fall  = ~q.s2 & q.s3;

	one_event_a: assert property (@(posedge pclk) disable iff (!presetn) rise |=> !rise)
		else $error("edge gave two events");

endmodule

// file: src/acq_timing.sv
`timescale 1ns/10ps
// How it works
// - Polling keeps per-channel results, round robin
// - Pacer mode converts each in-window pacer edge, streams samples
// - Scan pulse opens window; idle between windows
// - In pacer mode, only in-window pacer edges become strobes
// - Iteration walks first to last channel
// - Iteration countdown to zero closes window
// - Window close reloads iteration counter
// - Scan pulses counted; iterations programmable
// - Surplus pacer and scan pulses discarded
// - Single-clock: sample pacer also drives scan
// - Extra 32-bit count for delay/about
// - Enabled pause gate blocks scan pulses
// - Trigger edge and pause polarity selectable
// - Post: scan blocked until trigger
// - Delay: count scans after trigger, then acquire
// - About: acquire, then N windows after trigger
// - Pre: acquire from start, stop at trigger
// - Internal scan pacer: divided, 250k ceiling
// - External scan rising edge opens window
// - Internal sample pacer: divided, 250k ceiling
// - External sample pacer rising edge converts
// - Trigger on chosen rising or falling edge
module acq_timing
	import acq_pkg::*;
(
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// APB slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	// External pins
	input  wire logic             scan_pin,
	input  wire logic             sample_pacer_pin,
	input  wire logic             trig_pin,
	input  wire logic             pause_pin,
	// Converter
	output conv_req_t             conv,
	input  wire logic [ADC_W-1:0] adc_data,
	input  wire logic             adc_done,
	// Sample stream
	output sample_t               sample
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [CTRL_W-1:0]           ctrl;      // Control word
		logic [CH_W-1:0]             ch_first;  // First channel
		logic [CH_W-1:0]             ch_last;   // Last channel
		logic [31:0]                 iter_set;  // Iterations per window
		logic [31:0]                 scan_div;  // Scan divider
		logic [31:0]                 pace_div;  // Sample pacer divider
		logic [31:0]                 trig_set;  // Delay / hold count
		logic [31:0]                 scan_cnt;  // Scan pulses seen
		logic [31:0]                 iter_left; // Iterations left
		logic [31:0]                 trig_left; // Delay / hold left
		logic [3:0]                  tb_cnt;    // Time base prescaler
		logic [31:0]                 scan_ph;   // Scan divider phase
		logic [31:0]                 pace_ph;   // Pacer divider phase
		logic                        run_prev;  // Run bit last cycle
		logic                        win;       // Window open
		logic [CH_W-1:0]             chan;      // Next channel
		acq_state_t                  st;        // Trigger sequencer
		logic [CH_W-1:0]             pend_chan; // Channel in conversion
		logic [NCH-1:0][ADC_W-1:0]   result;    // Polling results
		conv_req_t                   conv;      // Strobe out
		sample_t                     smp;       // Sample out
		logic [31:0]                 prdata;    // Read data
	} core_t;

	core_t q; // Current state
	core_t n; // Next state

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic scan_rise;  // External scan edge
	logic pace_rise;  // External sample pacer edge
	logic trig_rise;  // Trigger rising
	logic trig_fall;  // Trigger falling
	logic pause_lvl;  // Pause gate level

	edge_sync u_scan (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (scan_pin),
		.level   (),
		.rise    (scan_rise),
		.fall    ()
	);

	edge_sync u_pace (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (sample_pacer_pin),
		.level   (),
		.rise    (pace_rise),
		.fall    ()
	);

	edge_sync u_trig (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (trig_pin),
		.level   (),
		.rise    (trig_rise),
		.fall    (trig_fall)
	);

	edge_sync u_pause (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (pause_pin),
		.level   (pause_lvl),
		.rise    (),
		.fall    ()
	);

	// ****************************************
	// Control decode and event routing
	// ****************************************
	logic        run;         // Operation running
	logic        pacer;       // Pacer mode
	trig_mode_t  mode;        // Trigger mode
	logic        start_evt;   // Run just set
	logic        tb_tick;     // 20 MHz time base tick
	logic [31:0] scan_lim;    // Clamped scan divider
	logic [31:0] pace_lim;    // Clamped pacer divider
	logic        scan_int;    // Internal scan pulse
	logic        pace_int;    // Internal pacer pulse
	logic        pace_evt;    // Selected pacer event
	logic        scan_raw;    // Selected scan event
	logic        pause_block; // Gate blocking
	logic        scan_pass;   // Scan past the gate
	logic        trig_evt;    // Selected trigger edge
	logic        scan_open;   // Scan opens a window
	logic        win_now;     // Window open this cycle
	logic [CH_W-1:0] cur_chan; // Channel to convert
	logic        step_ok;     // Pacer edge accepted

	assign run       = q.ctrl[B_RUN];
	assign pacer     = q.ctrl[B_PACER];
	assign mode      = trig_mode_t'(q.ctrl[B_MODE +: MODE_W]);
	assign start_evt = run & ~q.run_prev;
	assign tb_tick   = (q.tb_cnt == TB_LAST);

	// Dividers below the ceiling are raised to it rather than refused
	assign scan_lim = (q.scan_div < MIN_DIV) ? MIN_DIV : q.scan_div;
	assign pace_lim = (q.pace_div < MIN_DIV) ? MIN_DIV : q.pace_div;
	assign scan_int = run & tb_tick & (q.scan_ph >= scan_lim - 32'h1);
	assign pace_int = run & tb_tick & (q.pace_ph >= pace_lim - 32'h1);

	// Pacer source, external rising edges only
	assign pace_evt = q.ctrl[B_PACE_EXT] ? pace_rise : pace_int;

	// Single-clock routing ignores the scan pin
	always_comb begin
		if (q.ctrl[B_SINGLE]) begin
			scan_raw = pace_evt;
		end else if (q.ctrl[B_SCAN_EXT]) begin
			scan_raw = scan_rise;
		end else begin
			scan_raw = scan_int;
		end
	end

	// Gate blocks when the level differs from the pass level
	assign pause_block = q.ctrl[B_PAUSE_EN] & (pause_lvl == q.ctrl[B_PAUSE_LOW]);
	assign scan_pass   = run & scan_raw & ~pause_block;
	assign trig_evt    = q.ctrl[B_TRIG_FALL] ? trig_fall : trig_rise;

	// Scan opens only in an acquiring state and with no window open
	assign scan_open = scan_pass & pacer & ~q.win & ~start_evt
		& ((q.st == ST_ACQ) | (q.st == ST_HOLD));
	assign win_now  = q.win | scan_open;
	assign cur_chan = q.win ? q.chan : q.ch_first;
	assign step_ok  = run & pacer & pace_evt & win_now & ~start_evt;

	// ****************************************
	// APB decode
	// ****************************************
	logic            res_hit;  // Result window hit
	logic [CH_W-1:0] res_idx;  // Result index
	logic            addr_ok;  // Mapped address
	logic [31:0]     rd_word;  // Read mux

	assign res_hit = (paddr >= OFS_RESULT) & (paddr < OFS_RES_END) & (paddr[1:0] == 2'h0);
	assign res_idx = paddr[2 +: CH_W];

	// Read mux; unmapped reads give zero and an error
	always_comb begin
		rd_word = '0;
		addr_ok = 1'b1;
		unique case (paddr)
			OFS_CTRL:     rd_word = 32'(q.ctrl);
			OFS_CHAN:     rd_word = 32'({q.ch_last, q.ch_first});
			OFS_ITER:     rd_word = q.iter_set;
			OFS_SCAN_DIV: rd_word = q.scan_div;
			OFS_PACE_DIV: rd_word = q.pace_div;
			OFS_TRIG_CNT: rd_word = q.trig_set;
			OFS_SCAN_CNT: rd_word = q.scan_cnt;
			OFS_STATUS:   rd_word = 32'({q.st, q.win, q.chan});
			default: begin
				addr_ok = res_hit;
				rd_word = res_hit ? 32'(q.result[res_idx]) : '0;
			end
		endcase
	end

	// Zero wait states; data captured in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata  = q.prdata;

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		n             = q;
		n.conv.strobe = 1'b0;
		n.smp.valid   = 1'b0;
		n.run_prev    = run;

		// Register writes
		if (psel && penable && pwrite) begin
			unique case (paddr)
				OFS_CTRL: n.ctrl = pwdata[CTRL_W-1:0];
				OFS_CHAN: begin
					n.ch_first = pwdata[CH_W-1:0];
					n.ch_last  = pwdata[CH_LAST_LSB +: CH_W];
				end
				OFS_ITER:     n.iter_set = pwdata;
				OFS_SCAN_DIV: n.scan_div = pwdata;
				OFS_PACE_DIV: n.pace_div = pwdata;
				OFS_TRIG_CNT: n.trig_set = pwdata;
				default: ;
			endcase
		end

		// Read data for the coming access phase
		if (psel && !penable) begin
			n.prdata = rd_word;
		end

		// Time base and internal dividers, held at zero when stopped
		n.tb_cnt = (!run || tb_tick) ? '0 : q.tb_cnt + 4'h1;
		if (!run) begin
			n.scan_ph = '0;
			n.pace_ph = '0;
		end else if (tb_tick) begin
			n.scan_ph = scan_int ? '0 : q.scan_ph + 32'h1;
			n.pace_ph = pace_int ? '0 : q.pace_ph + 32'h1;
		end

		// Converter answer: result register or sample stream
		if (adc_done) begin
			if (pacer) begin
				n.smp = '{valid: 1'b1, chan: q.pend_chan, data: adc_data};
			end else begin
				n.result[q.pend_chan] = adc_data;
			end
		end

		if (!run) begin
			// Stop closes any window and rearms the iteration counter
			n.st        = ST_IDLE;
			n.win       = 1'b0;
			n.iter_left = q.iter_set;
		end else if (start_evt) begin
			n.scan_cnt  = '0;
			n.win       = 1'b0;
			n.iter_left = q.iter_set;
			n.chan      = q.ch_first;
			unique case (mode)
				MODE_POST, MODE_DELAY: n.st = ST_WAIT;
				default:               n.st = ST_ACQ;
			endcase
		end else begin
			if (scan_pass) begin
				n.scan_cnt = q.scan_cnt + 32'h1;
			end

			// Polling: walk channels on every pacer edge, no window
			if (!pacer && pace_evt) begin
				n.conv      = '{strobe: 1'b1, chan: q.chan};
				n.pend_chan = q.chan;
				n.chan      = (q.chan == q.ch_last) ? q.ch_first : q.chan + 1'b1;
			end

			// Window opens on an accepted scan pulse
			if (scan_open) begin
				n.win  = 1'b1;
				n.chan = q.ch_first;
			end

			// Pacer edge inside the window converts one channel
			if (step_ok) begin
				n.conv      = '{strobe: 1'b1, chan: cur_chan};
				n.pend_chan = cur_chan;
				if (cur_chan == q.ch_last) begin
					n.chan = q.ch_first;
					if (q.iter_left <= 32'h1) begin
						n.win       = 1'b0;
						n.iter_left = q.iter_set;
					end else begin
						n.iter_left = q.iter_left - 32'h1;
					end
				end else begin
					n.chan = cur_chan + 1'b1;
				end
			end

			// Trigger sequencer; the Pre-mode stop wins over the window
			unique case (q.st)
				ST_WAIT: if (trig_evt) begin
					if (mode == MODE_DELAY && q.trig_set != '0) begin
						n.st        = ST_DELAY;
						n.trig_left = q.trig_set;
					end else begin
						n.st = ST_ACQ;
					end
				end
				ST_DELAY: if (scan_pass) begin
					n.trig_left = q.trig_left - 32'h1;
					if (q.trig_left == 32'h1) begin
						n.st = ST_ACQ;
					end
				end
				ST_ACQ: if (trig_evt) begin
					if (mode == MODE_PRE) begin
						n.st        = ST_DONE;
						n.win       = 1'b0;
						n.iter_left = q.iter_set;
					end else if (mode == MODE_ABOUT) begin
						n.trig_left = q.trig_set;
						n.st        = (q.trig_set == '0) ? ST_DONE : ST_HOLD;
					end
				end
				ST_HOLD: if (scan_open) begin
					n.trig_left = q.trig_left - 32'h1;
					if (q.trig_left == 32'h1) begin
						n.st = ST_DONE; // Last window still runs to its end
					end
				end
				default: ;
			endcase
		end
	end

	// Register all state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign conv   = q.conv;
	assign sample = q.smp;

	// ****************************************
	// Checks
	// ****************************************
	logic [15:0] gap_q;  // Cycles since internal scan pulse
	logic        seen_q; // One internal scan pulse seen

	// Gap counter for the rate ceiling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q  <= '0;
			seen_q <= 1'b0;
		end else if (scan_int) begin
			gap_q  <= '0;
			seen_q <= 1'b1;
		end else if (gap_q != '1) begin
			gap_q <= gap_q + 16'h1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	strobe_in_window_a: assert property (q.conv.strobe && pacer |-> $past(q.win) || $past(scan_open))
		else $error("strobe outside window");
	idle_no_strobe_a: assert property (run && pacer && !win_now |=> !q.conv.strobe)
		else $error("strobe while idle");
	chan_wrap_a: assert property (step_ok && cur_chan == q.ch_last && !(psel && pwrite) |=> q.chan == q.ch_first)
		else $error("channel did not wrap");
	iter_reload_a: assert property (run && $fell(q.win) && $stable(q.iter_set) |-> q.iter_left == q.iter_set)
		else $error("iteration count not reloaded");
	pause_gate_a: assert property (pause_block |-> !scan_open && !scan_pass)
		else $error("scan passed closed gate");
	post_block_a: assert property (q.st == ST_WAIT |-> !scan_open ##1 !q.win)
		else $error("window before trigger");
	pre_stop_a: assert property (run && !start_evt && q.st == ST_ACQ && mode == MODE_PRE && trig_evt
		&& !(psel && pwrite) |=> q.st == ST_DONE && !q.win)
		else $error("pre mode did not stop");
	scan_count_a: assert property (run && !start_evt && scan_pass |=> q.scan_cnt == $past(q.scan_cnt) + 32'h1)
		else $error("scan pulse not counted");
	scan_rate_a: assert property (scan_int && seen_q |-> gap_q >= 16'(MIN_GAP_CYC - 1))
		else $error("internal scan too fast");
	open_busy_a: assert property (q.win && scan_pass |-> !scan_open)
		else $error("scan accepted in open window");

	window_cov: cover property (scan_open ##[1:1000] $fell(q.win));
	pre_cov:    cover property (q.st == ST_ACQ && mode == MODE_PRE ##1 q.st == ST_DONE);
	hold_cov:   cover property (q.st == ST_HOLD ##1 q.st == ST_DONE);
	poll_cov:   cover property (!pacer && adc_done);

endmodule

// file: testbench/ext_src.sv
`timescale 1ns/10ps
module ext_src
	import acq_pkg::*;
(
	// Clock
	input  wire logic              pclk,
	// Converter side
	input  wire conv_req_t         conv,
	output logic [ADC_W-1:0]       adc_data,
	output logic                   adc_done,
	// Pins
	output logic                   scan_pin,
	output logic                   sample_pacer_pin,
	output logic                   trig_pin,
	output logic                   pause_pin
);
	logic [3:0]      pins_q; // Pause, trigger, pacer, scan
	logic [1:0]      wait_q; // Conversion in flight
	logic [CH_W-1:0] ch_q;   // Channel being converted

	assign {pause_pin, trig_pin, sample_pacer_pin, scan_pin} = pins_q;

	initial begin
		pins_q   = 4'h0;
		adc_done = 1'b0;
		adc_data = 12'h000;
		wait_q   = 2'h0;
		ch_q     = 4'h0;
	end

	// Converter answers three edges after a strobe; bus toggles when stale
	always @(posedge pclk) begin
		adc_done <= 1'b0;
		adc_data <= ~adc_data;
		if (wait_q == 2'h1) begin
			adc_done <= 1'b1;
			adc_data <= {8'ha5, ch_q};
		end
		if (conv.strobe) begin
			wait_q <= 2'h3;
			ch_q   <= conv.chan;
		end else if (wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
		end
	end

	// Rising edge, then a gap that keeps the rate under the ceiling
	task pulse(input int i);
		@(posedge pclk);
		pins_q[i] <= 1'b1;
		repeat (4) @(posedge pclk);
		pins_q[i] <= 1'b0;
		repeat (MIN_GAP_CYC) @(posedge pclk);
	endtask

	// Level change on a pin, then settle
	task set_pin(input int i, input logic v);
		@(posedge pclk);
		pins_q[i] <= v;
		repeat (MIN_GAP_CYC) @(posedge pclk);
	endtask
endmodule

// file: testbench/adc_acquisition_timing_control_tb.sv
`timescale 1ns/10ps
module adc_acquisition_timing_control_tb
	import acq_pkg::*;
;
	logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, rd;
	wire              scan_pin, sample_pacer_pin, trig_pin, pause_pin, adc_done;
	wire  [ADC_W-1:0] adc_data;
	conv_req_t        conv;
	sample_t          sample;
	int               error_cnt, samples_checked, cyc, scnt;
	logic [CH_W-1:0]  chq[$]; // Strobed channels

	acq_timing u_acq_timing (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scan_pin(scan_pin), .sample_pacer_pin(sample_pacer_pin),
		.trig_pin(trig_pin), .pause_pin(pause_pin), .conv(conv), .adc_data(adc_data),
		.adc_done(adc_done), .sample(sample));
	ext_src u_ext_src (.pclk(pclk), .conv(conv), .adc_data(adc_data), .adc_done(adc_done),
		.scan_pin(scan_pin), .sample_pacer_pin(sample_pacer_pin), .trig_pin(trig_pin),
		.pause_pin(pause_pin));

	// ****************
	// Helpers
	// ****************
	always #2.5 pclk = ~pclk;

	// Strobe and sample monitor; hang guard
	always @(posedge pclk) begin
		if (conv.strobe === 1'b1) chq.push_back(conv.chan);
		if (sample.valid === 1'b1) begin
			scnt++;
			chk(32'(sample.data), 32'({8'ha5, sample.chan}));
		end
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			results();
		end
	end

	task results();
		if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask

	// One APB transfer; holds the request until pready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Compare strobed channels, packed a nibble each
	task strobes(input int n, input logic [31:0] chs);
		chk(32'(chq.size()), 32'(n));
		for (int i = 0; i < n; i++) chk(32'(chq[i]), 32'(chs[4*i+:4]));
		chq.delete();
	endtask

	task p(input int i);
		u_ext_src.pulse(i);
	endtask

	// ****************
	// Scenarios
	// ****************
	task t_regs();
		rdc(OFS_CTRL, 32'h0);
		rdc(OFS_STATUS, 32'h0);
		apb(1'b0, 8'h30, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, OFS_CHAN, 32'h32);
		rdc(OFS_CHAN, 32'h32);
		apb(1'b1, OFS_ITER, 32'h2);
		rdc(OFS_ITER, 32'h2);
	endtask

	// Two channels, two iterations; stray and surplus pulses dropped
	task t_window();
		scnt = 0;
		apb(1'b1, OFS_CTRL, 32'h303);
		p(1);
		p(0);
		p(1);
		p(0);
		repeat (4) p(1);
		strobes(4, 32'h3232);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[4], 1'b0);
		p(0);
		repeat (4) p(1);
		strobes(4, 32'h3232);
		chk(scnt, 8);
	endtask

	// Pacer doubles as scan; scan pin ignored
	task t_single();
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_CHAN, 32'h55);
		apb(1'b1, OFS_ITER, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h603);
		p(0);
		p(1);
		p(1);
		strobes(2, 32'h55);
	endtask

	// Falling trigger releases scan pulses
	task t_post();
		apb(1'b1, OFS_CTRL, 32'h0);
		u_ext_src.set_pin(2, 1'b1);
		apb(1'b1, OFS_CTRL, 32'h327);
		p(0);
		p(1);
		strobes(0, 32'h0);
		u_ext_src.set_pin(2, 1'b0);
		p(0);
		p(1);
		strobes(1, 32'h5);
	endtask

	// Pass-on-low gate
	task t_pause();
		apb(1'b1, OFS_CTRL, 32'h0);
		u_ext_src.set_pin(3, 1'b1);
		apb(1'b1, OFS_CTRL, 32'h3c3);
		p(0);
		p(1);
		strobes(0, 32'h0);
		rdc(OFS_SCAN_CNT, 32'h0);
		u_ext_src.set_pin(3, 1'b0);
		p(0);
		p(1);
		strobes(1, 32'h5);
		rdc(OFS_SCAN_CNT, 32'h1);
	endtask

	// Trigger closes an open window at once
	task t_pre();
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_ITER, 32'h3);
		apb(1'b1, OFS_CTRL, 32'h313);
		p(0);
		p(1);
		u_ext_src.set_pin(2, 1'b1);
		p(1);
		p(0);
		p(1);
		strobes(1, 32'h5);
	endtask

	// Delay: two scan pulses after the trigger pass before a window opens
	task t_delay();
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_ITER, 32'h1);
		apb(1'b1, OFS_TRIG_CNT, 32'h2);
		u_ext_src.set_pin(2, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h30b);
		p(0);
		u_ext_src.set_pin(2, 1'b1);
		p(0);
		p(0);
		p(1);
		strobes(0, 32'h0);
		p(0);
		p(1);
		strobes(1, 32'h5);
		rdc(OFS_STATUS, 32'h65);
	endtask

	// About: acquire from start, then two more windows after the trigger
	task t_about();
		apb(1'b1, OFS_CTRL, 32'h0);
		u_ext_src.set_pin(2, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h30f);
		p(0);
		p(1);
		u_ext_src.set_pin(2, 1'b1);
		repeat (3) begin
			p(0);
			p(1);
		end
		strobes(3, 32'h555);
		rdc(OFS_STATUS, 32'ha5);
	endtask

	// Internal pacers; dividers below the ceiling run at the ceiling
	task t_internal();
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_ITER, 32'h2);
		apb(1'b1, OFS_SCAN_DIV, 32'h1);
		apb(1'b1, OFS_PACE_DIV, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h3);
		repeat (2 * MIN_GAP_CYC + 100) @(posedge pclk);
		strobes(2, 32'h55);
		rdc(OFS_SCAN_CNT, 32'h2);
	endtask

	// Round robin into per-channel results
	task t_poll();
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_CHAN, 32'h10);
		apb(1'b1, OFS_CTRL, 32'h201);
		repeat (3) p(1);
		strobes(3, 32'h010);
		rdc(OFS_RESULT, 32'ha50);
		rdc(OFS_RESULT + 8'h04, 32'ha51);
	endtask

	initial begin
		pclk            = 1'b0;
		presetn         = 1'b0;
		psel            = 1'b0;
		penable         = 1'b0;
		pwrite          = 1'b0;
		paddr           = 8'h00;
		pwdata          = 32'h0;
		error_cnt       = 0;
		samples_checked = 0;
		cyc             = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_window();
		t_single();
		t_post();
		t_pause();
		t_pre();
		t_delay();
		t_about();
		t_internal();
		t_poll();
		results();
	end
endmodule
